// ===== cag_addr_gen.sv
`timescale 1ns/1ps
`include "cag_regs.svh"

// Overview of operation
// [RULE1]: Sequential PC advances by instruction byte length
// [RULE2]: Relative target: sign-extended displacement plus next
// [RULE3]: Short branch and conditionals use relative form
// [RULE4]: Absolute call/branch load full 16-bit immediate
// [RULE5]: Short-window call reaches 0800H to 0FFFH only
// [RULE6]: Table call indexes vector table by bits 1-5
// [RULE7]: Register branch loads accumulator pair into PC
// [RULE8]: Multiply implies A and X, product to pair
// [RULE9]: Divide uses pair; adjust, rotate use A
// [RULE10]: Bank flags plus 3-bit code pick register
// [RULE11]: Codes map X,A,C,B,E,D,L,H and AX..HL
// [RULE12]: Direct addressing uses 16-bit immediate
// [RULE13]: Short direct bit 8 set below 20H
// [RULE14]: Short window splits RAM and special registers
// [RULE15]: Word short direct operands even only
// [RULE16]: Special-register address is FF page plus immediate
// [RULE17]: Word special registers at even addresses only
// [RULE18]: Indirect uses DE or HL of bank
// [RULE19]: Based: HL plus zero-extended offset, no carry
// [RULE20]: Based indexed: HL plus B or C
// [RULE21]: Short call target is 0800H plus immediate
// [RULE22]: Vector entries are words, low byte first
module cag_addr_gen
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Decoder request
	input  wire logic                 req_valid_in,
	input  wire cag_pkg::cag_req_s    req_in,
	// Bank flags
	input  wire logic                 bank_select_low_in,
	input  wire logic                 bank_select_high_in,
	// Register bank read data
	input  wire logic [15:0]          accumulator_pair_in,
	input  wire logic [15:0]          pointer_pair_two_in,
	input  wire logic [15:0]          base_pointer_pair_in,
	input  wire logic [7:0]           reg_b_in,
	input  wire logic [7:0]           reg_c_in,
	// Memory read bus for vector table
	input  wire logic                 mem_rdata_valid_in,
	input  wire logic [7:0]           mem_rdata_in,
	// Program counter
	output logic [15:0]               program_counter_out,
	output logic                      busy_out,
	// Vector table memory request
	output logic                      mem_rd_out,
	output logic [15:0]               mem_addr_out,
	// Operand address
	output cag_pkg::cag_opaddr_s      opaddr_out,
	// Register selection
	output cag_pkg::cag_regsel_s      regsel_out
);

	logic [15:0]             program_counter;
	logic [15:0]             next_program_counter;
	cag_pkg::cag_vt_state_e  vt_state;
	cag_pkg::cag_vt_state_e  next_vt_state;
	logic [7:0]              vt_low;
	logic [15:0]             vt_addr;
	logic                    mem_rd;
	logic                    busy;
	cag_pkg::cag_opaddr_s    opaddr;
	cag_pkg::cag_regsel_s    regsel;

	wire logic [15:0]        seq_pc;
	wire logic [15:0]        rel_pc;
	wire logic [15:0]        short_pc;
	wire logic [15:0]        vt_entry;
	wire logic [4:0]         reg_index;
	wire logic [3:0]         pair_index;
	wire logic [3:0]         ptr_index;
	wire logic [4:0]         acc_index;
	wire logic [4:0]         x_index;
	wire logic [3:0]         ax_index;
	wire logic [1:0]         ptr_code;
	wire logic [15:0]        ptr_value;
	wire logic [7:0]         idx_value;
	wire cag_pkg::cag_opaddr_s opaddr_comb;
	wire logic               take;
	wire logic               vt_start;
	logic [4:0]              implied_src;
	logic [3:0]              implied_dst;

	// Address of the following instruction
	assign seq_pc   = 16'(program_counter + {13'h0000, req_in.inst_len});                   // [RULE1]
	// Displacement bit 7 replicated into the upper byte
	assign rel_pc   = 16'(seq_pc + {{8{req_in.imm8[7]}}, req_in.imm8});                      // [RULE2]
	// Only 11 bits kept, so the target can never leave the window
	assign short_pc = `CAG_SHORT_CALL_BASE | {5'h00, req_in.imm16[10:0]};                    // [RULE5] [RULE21]
	// Entry word sits at base plus twice the opcode field
	assign vt_entry = `CAG_VTAB_BASE | {10'h000, req_in.opcode[5:1], 1'b0};                  // [RULE6] [RULE22]
	assign take     = req_valid_in && (vt_state == cag_pkg::CAG_VT_IDLE);
	assign vt_start = take && req_in.vtab_call;

	// Pointer is DE when the pair code names DE, otherwise HL
	assign ptr_code  = (req_in.pair_code == `CAG_PAIR_DE) ? `CAG_PAIR_DE : `CAG_PAIR_HL;     // [RULE18]
	assign ptr_value = (ptr_code == `CAG_PAIR_DE) ? pointer_pair_two_in : base_pointer_pair_in;
	assign idx_value = req_in.idx_use_b ? reg_b_in : reg_c_in;                                // [RULE20]

	cag_bank_select u_bank
	(
		.bank_select_low_in  (bank_select_low_in),
		.bank_select_high_in (bank_select_high_in),
		.reg_code_in         (req_in.reg_code),
		.pair_code_in        (req_in.pair_code),
		.ptr_code_in         (ptr_code),
		.reg_index_out       (reg_index),
		.pair_index_out      (pair_index),
		.ptr_index_out       (ptr_index),
		.acc_index_out       (acc_index),
		.x_index_out         (x_index),
		.acc_pair_index_out  (ax_index)
	);

	cag_opaddr u_opaddr
	(
		.mode_in  (req_in.op_mode),
		.imm8_in  (req_in.imm8),
		.imm16_in (req_in.imm16),
		.word_in  (req_in.word_op),
		.ptr_in   (ptr_value),
		.base_in  (base_pointer_pair_in),
		.index_in (idx_value),
		.res_out  (opaddr_comb)
	);

	// Implied operands: src carries the byte register, dst the pair
	always_comb
	begin
		implied_src = 5'h00;
		implied_dst = 4'h0;
		case (req_in.implied)
			cag_pkg::CAG_IMP_MUL:
			begin
				implied_src = x_index;                                                      // [RULE8]
				implied_dst = ax_index;                                                     // [RULE8]
			end
			cag_pkg::CAG_IMP_DIV:  implied_dst = ax_index;                                  // [RULE9]
			cag_pkg::CAG_IMP_ADJ:  implied_src = acc_index;                                 // [RULE9]
			cag_pkg::CAG_IMP_ROT:  implied_src = acc_index;                                 // [RULE9]
			default:               implied_src = 5'h00;
		endcase
	end

	// Program counter selection
	always_comb
	begin
		next_program_counter = program_counter;
		if (take && !req_in.vtab_call)
		begin
			case (req_in.pc_mode)
				cag_pkg::CAG_PC_HOLD:   next_program_counter = program_counter;
				cag_pkg::CAG_PC_SEQ:    next_program_counter = seq_pc;                      // [RULE1]
				cag_pkg::CAG_PC_REL:    next_program_counter = rel_pc;                      // [RULE3]
				cag_pkg::CAG_PC_ABS:    next_program_counter = req_in.imm16;                // [RULE4]
				cag_pkg::CAG_PC_SHORT:  next_program_counter = short_pc;                    // [RULE21]
				cag_pkg::CAG_PC_REGJMP: next_program_counter = accumulator_pair_in;         // [RULE7]
				default:                next_program_counter = program_counter;
			endcase
		end
		else if ((vt_state == cag_pkg::CAG_VT_HIGH) && mem_rdata_valid_in)
		begin
			next_program_counter = {mem_rdata_in, vt_low};                                  // [RULE22]
		end
	end

	// Vector fetch walk: low byte, then high byte
	always_comb
	begin
		next_vt_state = vt_state;
		case (vt_state)
			cag_pkg::CAG_VT_IDLE: if (vt_start) next_vt_state = cag_pkg::CAG_VT_LOW;
			cag_pkg::CAG_VT_LOW:  if (mem_rdata_valid_in) next_vt_state = cag_pkg::CAG_VT_HIGH;
			cag_pkg::CAG_VT_HIGH: if (mem_rdata_valid_in) next_vt_state = cag_pkg::CAG_VT_IDLE;
			default:              next_vt_state = cag_pkg::CAG_VT_IDLE;
		endcase
	end

	// Register selection bundle
	always_comb
	begin
		regsel.reg_index   = reg_index;                                                     // [RULE10] [RULE11]
		regsel.pair_index  = pair_index;                                                    // [RULE11]
		regsel.implied_src = implied_src;
		regsel.implied_dst = implied_dst;
		opaddr             = opaddr_comb;
		if (req_in.op_mode == cag_pkg::CAG_OP_IND || req_in.op_mode == cag_pkg::CAG_OP_BASED
			|| req_in.op_mode == cag_pkg::CAG_OP_BIDX)
		begin
			regsel.pair_index = ptr_index;                                                  // [RULE18]
		end
	end

	// Program counter and vector walk registers
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			program_counter <= `CAG_PC_RESET;
			vt_state        <= cag_pkg::CAG_VT_IDLE;
			vt_low          <= 8'h00;
			vt_addr         <= 16'h0000;
			mem_rd          <= 1'b0;
			busy            <= 1'b0;
		end
		else
		begin
			program_counter <= next_program_counter;
			vt_state        <= next_vt_state;
			busy            <= (next_vt_state != cag_pkg::CAG_VT_IDLE); // Registered so the pin has no decode glitch
			if (vt_start)
			begin
				vt_addr <= vt_entry;
				mem_rd  <= 1'b1;
			end
			else if (vt_state == cag_pkg::CAG_VT_LOW && mem_rdata_valid_in)
			begin
				vt_low  <= mem_rdata_in;                                                    // [RULE22]
				vt_addr <= 16'(vt_addr + 16'h0001);
				mem_rd  <= 1'b1;
			end
			else if (vt_state == cag_pkg::CAG_VT_HIGH && mem_rdata_valid_in)
			begin
				mem_rd <= 1'b0;
			end
		end
	end

	// Registered copies of the combinational results
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			opaddr_out <= '0;
			regsel_out <= '0;
		end
		else if (take)
		begin
			opaddr_out <= opaddr;
			regsel_out <= regsel;
		end
		else
		begin
			opaddr_out.valid <= 1'b0;
		end
	end

	assign program_counter_out = program_counter;
	assign mem_addr_out        = vt_addr;
	assign mem_rd_out          = mem_rd;
	assign busy_out            = busy;

endmodule // cag_addr_gen

// ===== cag_regs.svh
`ifndef CAG_REGS_SVH
`define CAG_REGS_SVH

// Fixed address windows and constants
`define CAG_SHORT_CALL_BASE   16'h0800
`define CAG_VTAB_BASE         16'h0040
`define CAG_VTAB_LAST         16'h007f
`define CAG_SADDR_PAGE        8'hfe
`define CAG_SADDR_SFR_LIMIT   8'h20
`define CAG_SFR_PAGE          8'hff
`define CAG_SFR_GAP_LO        8'hd0
`define CAG_SFR_GAP_HI        8'hdf
`define CAG_SADDR_RAM_LO      16'hfe20
`define CAG_SADDR_RAM_HI      16'hfeff
`define CAG_SADDR_SFR_HI      16'hff1f
`define CAG_PC_RESET          16'h0000
`define CAG_REG_X             3'h0
`define CAG_REG_A             3'h1
`define CAG_REG_C             3'h2
`define CAG_REG_B             3'h3
`define CAG_PAIR_AX           2'h0
`define CAG_PAIR_DE           2'h2
`define CAG_PAIR_HL           2'h3

`endif

// ===== cag_pkg.sv
package cag_pkg;

	// Program counter update modes
	typedef enum logic [5:0]
	{
		CAG_PC_HOLD   = 6'h01,
		CAG_PC_SEQ    = 6'h02,
		CAG_PC_REL    = 6'h04,
		CAG_PC_ABS    = 6'h08,
		CAG_PC_SHORT  = 6'h10,
		CAG_PC_REGJMP = 6'h20
	} cag_pc_mode_e;

	// Operand addressing modes
	typedef enum logic [3:0]
	{
		CAG_OP_NONE   = 4'h0,
		CAG_OP_DIRECT = 4'h1,
		CAG_OP_SADDR  = 4'h2,
		CAG_OP_SFR    = 4'h3,
		CAG_OP_IND    = 4'h4,
		CAG_OP_BASED  = 4'h5,
		CAG_OP_BIDX   = 4'h6
	} cag_op_mode_e;

	// Implied-register instruction kinds
	typedef enum logic [2:0]
	{
		CAG_IMP_NONE = 3'h0,
		CAG_IMP_MUL  = 3'h1,
		CAG_IMP_DIV  = 3'h2,
		CAG_IMP_ADJ  = 3'h3,
		CAG_IMP_ROT  = 3'h4
	} cag_imp_e;

	// Vector table walk states
	typedef enum logic [2:0]
	{
		CAG_VT_IDLE = 3'b001,
		CAG_VT_LOW  = 3'b010,
		CAG_VT_HIGH = 3'b100
	} cag_vt_state_e;

	// Decoded request from the instruction decoder
	typedef struct packed
	{
		cag_pc_mode_e pc_mode;
		logic [2:0]   inst_len;
		logic [7:0]   imm8;
		logic [15:0]  imm16;
		logic         vtab_call;
		logic [7:0]   opcode;
		cag_op_mode_e op_mode;
		logic [1:0]   pair_code;
		logic [2:0]   reg_code;
		logic         word_op;
		logic         idx_use_b;
		cag_imp_e     implied;
	} cag_req_s;

	// Operand address result
	typedef struct packed
	{
		logic        valid;
		logic [15:0] addr;
		logic        misaligned;
		logic        in_ram;
		logic        in_sfr;
	} cag_opaddr_s;

	// Register select result
	typedef struct packed
	{
		logic [4:0] reg_index;
		logic [3:0] pair_index;
		logic [4:0] implied_src;
		logic [3:0] implied_dst;
	} cag_regsel_s;

endpackage

// ===== cag_bank_select.sv
`timescale 1ns/1ps
`include "cag_regs.svh"

// Maps bank flags plus opcode codes to flat register-file indices
module cag_bank_select
(
	// Bank flags
	input  wire logic       bank_select_low_in,
	input  wire logic       bank_select_high_in,
	// Codes
	input  wire logic [2:0] reg_code_in,
	input  wire logic [1:0] pair_code_in,
	input  wire logic [1:0] ptr_code_in,
	// Results
	output logic [4:0]      reg_index_out,
	output logic [3:0]      pair_index_out,
	output logic [3:0]      ptr_index_out,
	output logic [4:0]      acc_index_out,
	output logic [4:0]      x_index_out,
	output logic [3:0]      acc_pair_index_out
);

	wire logic [1:0] bank;

	// Byte code order X,A,C,B,E,D,L,H is the flat order inside a bank
	assign bank               = {bank_select_high_in, bank_select_low_in};
	assign reg_index_out      = {bank, reg_code_in};
	assign pair_index_out     = {bank, pair_code_in};
	assign ptr_index_out      = {bank, ptr_code_in};
	assign acc_index_out      = {bank, `CAG_REG_A};
	assign x_index_out        = {bank, `CAG_REG_X};
	assign acc_pair_index_out = {bank, `CAG_PAIR_AX};

endmodule // cag_bank_select

// ===== cag_opaddr.sv
`timescale 1ns/1ps
`include "cag_regs.svh"

// Combinational operand address former
module cag_opaddr
(
	// Request
	input  wire cag_pkg::cag_op_mode_e mode_in,
	input  wire logic [7:0]            imm8_in,
	input  wire logic [15:0]           imm16_in,
	input  wire logic                  word_in,
	// Register values
	input  wire logic [15:0]           ptr_in,
	input  wire logic [15:0]           base_in,
	input  wire logic [7:0]            index_in,
	// Result
	output cag_pkg::cag_opaddr_s       res_out
);

	wire logic [15:0] saddr;
	wire logic [15:0] sfr;
	wire logic [15:0] based;
	wire logic [15:0] bidx;
	wire logic        sfr_gap;
	wire logic        op_valid;
	wire logic        misaligned;
	wire logic        in_ram;
	wire logic        in_sfr;
	logic [15:0]      addr;

	// Bit 8 set only for immediates below the SFR split
	assign saddr   = {7'h7f, (imm8_in < `CAG_SADDR_SFR_LIMIT), imm8_in};                  // [RULE13]
	assign sfr     = {`CAG_SFR_PAGE, imm8_in};                                             // [RULE16]
	assign sfr_gap = (imm8_in >= `CAG_SFR_GAP_LO) && (imm8_in <= `CAG_SFR_GAP_HI);           // [RULE16]
	// Carry out of bit 15 simply falls off the 16-bit sum
	assign based   = 16'(base_in + {8'h00, imm8_in});                                      // [RULE19]
	assign bidx    = 16'(base_in + {8'h00, index_in});                                     // [RULE20]

	always_comb
	begin
		case (mode_in)
			cag_pkg::CAG_OP_DIRECT: addr = imm16_in;                                         // [RULE12]
			cag_pkg::CAG_OP_SADDR:  addr = saddr;
			cag_pkg::CAG_OP_SFR:    addr = sfr;
			cag_pkg::CAG_OP_IND:    addr = ptr_in;                                           // [RULE18]
			cag_pkg::CAG_OP_BASED:  addr = based;
			cag_pkg::CAG_OP_BIDX:   addr = bidx;
			default:                addr = 16'h0000;
		endcase
	end

	assign op_valid   = (mode_in != cag_pkg::CAG_OP_NONE);
	// Word forms only at even addresses; SFR gap is also flagged
	assign misaligned = ((mode_in == cag_pkg::CAG_OP_SADDR) && word_in && imm8_in[0])   // [RULE15]
		|| ((mode_in == cag_pkg::CAG_OP_SFR) && (word_in && imm8_in[0] || sfr_gap));         // [RULE17]
	assign in_ram     = (mode_in == cag_pkg::CAG_OP_SADDR) && (addr <= `CAG_SADDR_RAM_HI); // [RULE14]
	assign in_sfr     = (mode_in == cag_pkg::CAG_OP_SADDR) && (addr > `CAG_SADDR_RAM_HI);  // [RULE14]
	// One driver for the whole bundle, fields in the struct's order
	assign res_out    = {op_valid, addr, misaligned, in_ram, in_sfr};

endmodule // cag_opaddr

// ===== cag_addr_gen_checker.sv
`timescale 1ns/1ps
module cag_addr_gen_checker
(
	// Clock and reset
	input wire logic                 clk_in,
	input wire logic                 rst_in,
	// Request side
	input wire logic                 req_valid_in,
	input wire cag_pkg::cag_req_s    req_in,
	input wire logic                 bank_select_low_in,
	input wire logic                 bank_select_high_in,
	input wire logic [15:0]          accumulator_pair_in,
	input wire logic [15:0]          base_pointer_pair_in,
	input wire logic [7:0]           reg_b_in,
	input wire logic [7:0]           reg_c_in,
	input wire logic                 mem_rdata_valid_in,
	input wire logic [7:0]           mem_rdata_in,
	// Design outputs
	input wire logic [15:0]          program_counter_out,
	input wire logic                 busy_out,
	input wire logic                 mem_rd_out,
	input wire logic [15:0]          mem_addr_out,
	input wire cag_pkg::cag_opaddr_s opaddr_out,
	input wire cag_pkg::cag_regsel_s regsel_out
);
	// Take qualifier and expected operands, worked out apart from the design
	wire        take = req_valid_in && !busy_out;
	wire [7:0]  i8   = req_in.imm8;
	wire [15:0] nxt  = program_counter_out + {13'h0, req_in.inst_len};
	wire [15:0] rel  = nxt + {{8{i8[7]}}, i8};
	wire [15:0] hlb  = base_pointer_pair_in + {8'h0, i8};
	wire [15:0] hli  = base_pointer_pair_in + {8'h0, req_in.idx_use_b ? reg_b_in : reg_c_in};
	wire [1:0]  bank = {bank_select_high_in, bank_select_low_in};

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Table walk steps
	sequence s_vt_take; take && req_in.vtab_call; endsequence
	sequence s_vt_low; mem_rd_out && busy_out; endsequence
	sequence s_vt_high; busy_out && mem_rdata_valid_in && mem_addr_out[0]; endsequence

	property p_seq; take && req_in.pc_mode == cag_pkg::CAG_PC_SEQ |=> program_counter_out == $past(nxt); endproperty
	property p_rel; take && req_in.pc_mode == cag_pkg::CAG_PC_REL |=> program_counter_out == $past(rel); endproperty
	property p_abs; take && req_in.pc_mode == cag_pkg::CAG_PC_ABS |=> program_counter_out == $past(req_in.imm16);
	endproperty
	property p_short; take && req_in.pc_mode == cag_pkg::CAG_PC_SHORT
		|=> program_counter_out == {5'h01, $past(req_in.imm16[10:0])}; endproperty
	property p_regjmp; take && req_in.pc_mode == cag_pkg::CAG_PC_REGJMP
		|=> program_counter_out == $past(accumulator_pair_in); endproperty
	property p_vt_start; s_vt_take |=> s_vt_low ##0 mem_addr_out == {10'h001, $past(req_in.opcode[5:1]), 1'b0};
	endproperty
	property p_vt_end; s_vt_high |=> !busy_out && !mem_rd_out && program_counter_out[15:8] == $past(mem_rdata_in);
	endproperty
	property p_direct; take && req_in.op_mode == cag_pkg::CAG_OP_DIRECT
		|=> opaddr_out.valid && opaddr_out.addr == $past(req_in.imm16); endproperty
	property p_saddr; take && req_in.op_mode == cag_pkg::CAG_OP_SADDR
		|=> opaddr_out.addr == {7'h7f, ($past(i8) < 8'h20), $past(i8)}
		&& opaddr_out.in_ram == ($past(i8) >= 8'h20); endproperty
	property p_sfr; take && req_in.op_mode == cag_pkg::CAG_OP_SFR |=> opaddr_out.addr == {8'hff, $past(i8)}; endproperty
	property p_based; take && req_in.op_mode == cag_pkg::CAG_OP_BASED |=> opaddr_out.addr == $past(hlb); endproperty
	property p_bidx; take && req_in.op_mode == cag_pkg::CAG_OP_BIDX |=> opaddr_out.addr == $past(hli); endproperty
	property p_regsel; take |=> regsel_out.reg_index == {$past(bank), $past(req_in.reg_code)}; endproperty

	a_seq: assert property (p_seq) else $error("sequential pc step wrong");
	a_rel: assert property (p_rel) else $error("relative target wrong");
	a_abs: assert property (p_abs) else $error("absolute target wrong");
	a_short: assert property (p_short) else $error("short window call target wrong");
	a_regjmp: assert property (p_regjmp) else $error("register branch target wrong");
	a_vt_start: assert property (p_vt_start) else $error("table entry address wrong");
	a_vt_end: assert property (p_vt_end) else $error("table walk end wrong");
	a_direct: assert property (p_direct) else $error("direct address wrong");
	a_saddr: assert property (p_saddr) else $error("short direct address wrong");
	a_sfr: assert property (p_sfr) else $error("special register address wrong");
	a_based: assert property (p_based) else $error("based address wrong");
	a_bidx: assert property (p_bidx) else $error("based indexed address wrong");
	a_regsel: assert property (p_regsel) else $error("register index wrong");
endmodule // cag_addr_gen_checker

bind cag_addr_gen cag_addr_gen_checker u_chk (.*);

// ===== cag_mem_model.sv
`timescale 1ns/1ps
module cag_mem_model
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Read request from the block
	input  wire logic        slow_in,
	input  wire logic        mem_rd_in,
	input  wire logic [15:0] mem_addr_in,
	// Read answer
	output logic             rdata_valid_out,
	output logic [7:0]       rdata_out
);
	logic [1:0] wait_cnt;

	// One byte per request; the cycle after a pulse is skipped so the address can step
	always_ff @(posedge clk_in)
	begin
		rdata_valid_out <= 1'b0;
		rdata_out <= ~rdata_out; // Idle bus flips every bit each cycle, so shows the last byte every other cycle
		if (rst_in)
		begin
			wait_cnt <= 2'h0;
			rdata_out <= 8'h00;
		end
		else if (mem_rd_in && !rdata_valid_out)
		begin
			wait_cnt <= wait_cnt + 2'h1;
			if (wait_cnt == (slow_in ? 2'h3 : 2'h0))
			begin
				wait_cnt <= 2'h0;
				rdata_valid_out <= 1'b1;
				rdata_out <= mem_addr_in[7:0] + 8'h31; // Each entry byte from its own address
			end
		end
		else
			wait_cnt <= 2'h0;
	end
endmodule // cag_mem_model

// ===== tb_cag_addr_gen.sv
`timescale 1ns/1ps
module tb_cag_addr_gen;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	logic slow = 1'b0;
	logic [1:0] bank = 2'h0;
	logic [15:0] ax = 16'h0, de = 16'h0, hl = 16'h0, pc_exp = 16'h0, pc, maddr;
	logic [7:0] rb = 8'h0, rc = 8'h0, rdata;
	logic busy, mrd, rvalid;
	cag_pkg::cag_req_s req_in = '0;
	cag_pkg::cag_opaddr_s opa;
	cag_pkg::cag_regsel_s rs;
	int n_errors = 0;
	int tests_run = 0;

	always #5 clk_in = ~clk_in;

	cag_addr_gen dut_u (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
		.bank_select_low_in(bank[0]), .bank_select_high_in(bank[1]), .accumulator_pair_in(ax),
		.pointer_pair_two_in(de), .base_pointer_pair_in(hl), .reg_b_in(rb), .reg_c_in(rc),
		.mem_rdata_valid_in(rvalid), .mem_rdata_in(rdata), .program_counter_out(pc), .busy_out(busy),
		.mem_rd_out(mrd), .mem_addr_out(maddr), .opaddr_out(opa), .regsel_out(rs));
	cag_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .mem_rd_in(mrd),
		.mem_addr_in(maddr), .rdata_valid_out(rvalid), .rdata_out(rdata));

	task summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic cag_pkg::cag_req_s mk(cag_pkg::cag_pc_mode_e m, logic [2:0] l, cag_pkg::cag_op_mode_e o,
		logic [7:0] i8, logic [15:0] i16);
		cag_pkg::cag_req_s r;
		r = '0;
		r.pc_mode = m;
		r.inst_len = l;
		r.op_mode = o;
		r.imm8 = i8;
		r.imm16 = i16;
		return r;
	endfunction

	// One request, taken at the second edge; outputs are looked at just after it
	task go(input cag_pkg::cag_req_s r);
		@(posedge clk_in);
		req_in <= r;
		req_valid_in <= 1'b1;
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		#1;
	endtask

	task t_pc;
		for (int l = 1; l <= 4; l++)
		begin
			go(mk(cag_pkg::CAG_PC_SEQ, 3'(l), cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000));
			pc_exp = pc_exp + 16'(l);
			chk("pc_seq", pc, pc_exp);
		end
		go(mk(cag_pkg::CAG_PC_REL, 3'h2, cag_pkg::CAG_OP_NONE, 8'h7f, 16'h0000));
		pc_exp = pc_exp + 16'h0081;
		chk("pc_rel_fwd", pc, pc_exp);
		go(mk(cag_pkg::CAG_PC_REL, 3'h3, cag_pkg::CAG_OP_NONE, 8'h80, 16'h0000));
		pc_exp = pc_exp + 16'h0003 - 16'h0080;
		chk("pc_rel_back", pc, pc_exp);
		go(mk(cag_pkg::CAG_PC_ABS, 3'h3, cag_pkg::CAG_OP_NONE, 8'h00, 16'hffff));
		chk("pc_abs", pc, 16'hffff);
		go(mk(cag_pkg::CAG_PC_SHORT, 3'h2, cag_pkg::CAG_OP_NONE, 8'h00, 16'hffff));
		chk("pc_short_top", pc, 16'h0fff);
		go(mk(cag_pkg::CAG_PC_SHORT, 3'h2, cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000));
		chk("pc_short_base", pc, 16'h0800);
		ax <= 16'h1234;
		go(mk(cag_pkg::CAG_PC_REGJMP, 3'h1, cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000));
		chk("pc_regjmp", pc, 16'h1234);
		go(mk(cag_pkg::CAG_PC_HOLD, 3'h2, cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000));
		chk("pc_hold", pc, 16'h1234);
		pc_exp = 16'h1234;
		$display("test pc_update done");
	endtask

	// Table call with prompt and slow memory; a request sent while busy must be ignored
	task t_vt;
		cag_pkg::cag_req_s r;
		logic [15:0] a;
		int k;
		for (int i = 0; i < 4; i++)
		begin
			slow <= i[0];
			r = mk(cag_pkg::CAG_PC_HOLD, 3'h1, cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000);
			r.vtab_call = 1'b1;
			r.opcode = {2'h3, i[1] ? 5'h1f : 5'h00, 1'b1};
			a = 16'h0040 + {10'h0, r.opcode[5:1], 1'b0};
			go(r);
			chk("vt_addr", maddr, a);
			chk("vt_busy", {15'h0, busy}, 16'h0001);
			chk("vt_rd", {15'h0, mrd}, 16'h0001);
			go(mk(cag_pkg::CAG_PC_ABS, 3'h3, cag_pkg::CAG_OP_NONE, 8'h00, 16'hdead));
			for (k = 0; k < 40 && busy !== 1'b0; k++)
				@(posedge clk_in) #1;
			if (k == 40)
			begin
				n_errors++;
				summarize;
			end
			chk("vt_pc", pc, {a[7:0] + 8'h32, a[7:0] + 8'h31});
			chk("vt_rd_end", {15'h0, mrd}, 16'h0000);
		end
		$display("test vector_table done");
	endtask

	task op(input cag_pkg::cag_op_mode_e o, input logic [7:0] i8, input logic [15:0] i16, input logic w,
		input logic b, input logic [15:0] ea, input logic em, input logic [1:0] eg);
		cag_pkg::cag_req_s r;
		r = mk(cag_pkg::CAG_PC_SEQ, 3'h1, o, i8, i16);
		r.word_op = w;
		r.idx_use_b = b;
		r.pair_code = b ? 2'h2 : 2'h3;
		go(r);
		chk("op_valid", {15'h0, opa.valid}, 16'h0001);
		chk("op_addr", opa.addr, ea);
		chk("op_misaligned", {15'h0, opa.misaligned}, {15'h0, em});
		chk("op_region", {14'h0, opa.in_ram, opa.in_sfr}, {14'h0, eg});
	endtask

	task t_op;
		de <= 16'h1357;
		hl <= 16'hfff0;
		rb <= 8'h20;
		rc <= 8'h10;
		op(cag_pkg::CAG_OP_DIRECT, 8'h00, 16'hbeef, 1'b0, 1'b0, 16'hbeef, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_SADDR, 8'h20, 16'h0000, 1'b0, 1'b0, 16'hfe20, 1'b0, 2'h2);
		op(cag_pkg::CAG_OP_SADDR, 8'hff, 16'h0000, 1'b0, 1'b0, 16'hfeff, 1'b0, 2'h2);
		op(cag_pkg::CAG_OP_SADDR, 8'h1f, 16'h0000, 1'b0, 1'b0, 16'hff1f, 1'b0, 2'h1);
		op(cag_pkg::CAG_OP_SADDR, 8'h21, 16'h0000, 1'b1, 1'b0, 16'hfe21, 1'b1, 2'h2);
		op(cag_pkg::CAG_OP_SFR, 8'hcf, 16'h0000, 1'b0, 1'b0, 16'hffcf, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_SFR, 8'he3, 16'h0000, 1'b1, 1'b0, 16'hffe3, 1'b1, 2'h0);
		op(cag_pkg::CAG_OP_SFR, 8'hd5, 16'h0000, 1'b0, 1'b0, 16'hffd5, 1'b1, 2'h0);
		op(cag_pkg::CAG_OP_IND, 8'h00, 16'h0000, 1'b0, 1'b1, 16'h1357, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_IND, 8'h00, 16'h0000, 1'b0, 1'b0, 16'hfff0, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_BASED, 8'hff, 16'h0000, 1'b0, 1'b0, 16'h00ef, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_BIDX, 8'h00, 16'h0000, 1'b0, 1'b1, 16'h0010, 1'b0, 2'h0);
		op(cag_pkg::CAG_OP_BIDX, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0, 2'h0);
		$display("test operand_address done");
	endtask

	// Every bank with a spread of codes, using the multiply's implied operands
	task t_rs;
		cag_pkg::cag_req_s r;
		for (int i = 0; i < 8; i++)
		begin
			bank <= i[1:0];
			r = mk(cag_pkg::CAG_PC_SEQ, 3'h1, cag_pkg::CAG_OP_NONE, 8'h00, 16'h0000);
			r.reg_code = 3'(7 - i);
			r.pair_code = i[2:1];
			r.implied = cag_pkg::CAG_IMP_MUL;
			go(r);
			chk("reg_index", {11'h0, rs.reg_index}, {11'h0, i[1:0], r.reg_code});
			chk("pair_index", {12'h0, rs.pair_index}, {12'h0, i[1:0], i[2:1]});
			chk("mul_src", {11'h0, rs.implied_src}, {11'h0, i[1:0], 3'h0});
			chk("mul_dst", {12'h0, rs.implied_dst}, {12'h0, i[1:0], 2'h0});
		end
		// Divide, adjust and rotate in bank 3, left selected by the last pass above
		for (int k = 2; k <= 4; k++)
		begin
			r.implied = cag_pkg::cag_imp_e'(k);
			go(r);
			chk("imp_src", {11'h0, rs.implied_src}, (k == 2) ? 16'h0000 : 16'h0019);
			chk("imp_dst", {12'h0, rs.implied_dst}, (k == 2) ? 16'h000c : 16'h0000);
		end
		$display("test register_select done");
	endtask

	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		chk("reset_pc", pc, 16'h0000);
		chk("reset_busy", {15'h0, busy}, 16'h0000);
		t_pc;
		t_vt;
		t_op;
		t_rs;
		summarize;
	end
endmodule // tb_cag_addr_gen
